//--- hw/flmc_pkg.sv
// constants shared by the flash led mode control block
package flmc_pkg;
  // two-wire bus
  localparam logic [6:0] CHIP_ADDR = 7'h53;
  // register offsets
  localparam logic [7:0] MODE_SELECT_ADDR = 8'h10;
  localparam logic [7:0] TORCH_LEVEL_ADDR = 8'hA0;
  localparam logic [7:0] FLASH_LEVEL_ADDR = 8'hB0;
  localparam logic [7:0] FLASH_TIME_LIMIT_ADDR = 8'hC0;
  // power-on values
  localparam logic [3:0] MODE_SELECT_RST = 4'h0;
  localparam logic [3:0] TORCH_LEVEL_RST = 4'h7;
  localparam logic [3:0] FLASH_LEVEL_RST = 4'hA;
  localparam logic [3:0] FLASH_TIME_LIMIT_RST = 4'hB;
  // mode_select fields
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_B1_BIT = 1;
  localparam int MODE_B2_BIT = 2;
  localparam int STROBE_INHIBIT_BIT = 3;
  localparam logic [3:0] INDICATOR_CODE = 4'h0;
  // time base: one tick per millisecond
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int MS_W = 11;
  // timeout durations in ms for codes 0..7
  localparam logic [MS_W-1:0] TMO_MS_0 = 11'd60;
  localparam logic [MS_W-1:0] TMO_MS_1 = 11'd125;
  localparam logic [MS_W-1:0] TMO_MS_2 = 11'd250;
  localparam logic [MS_W-1:0] TMO_MS_3 = 11'd375;
  localparam logic [MS_W-1:0] TMO_MS_4 = 11'd500;
  localparam logic [MS_W-1:0] TMO_MS_5 = 11'd625;
  localparam logic [MS_W-1:0] TMO_MS_6 = 11'd750;
  localparam logic [MS_W-1:0] TMO_MS_7 = 11'd1100;
  typedef enum logic [1:0] {FLMC_IDLE, FLMC_BYTE, FLMC_ACK} flmc_i2c_st_t;
endpackage

//--- hw/flmc_i2c_rx.sv
// two-wire bus write-only slave receiver
`timescale 1ns/100ps
`default_nettype none
module flmc_i2c_rx
  import flmc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // bus pins
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  // register write port
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  flmc_i2c_st_t state;

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_prev;
  wire scl_fall = ~scl_s & scl_prev;
  wire start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_cond = scl_s & scl_prev & ~sda_prev & sda_s;
  wire addr_ok = (shreg[7:1] == CHIP_ADDR) & ~shreg[0];
  wire byte_ack = (byte_idx != 2'd0) | addr_ok;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin_in};
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= FLMC_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      byte_idx <= 2'd0;
      sda_pin_out <= 1'b0;
      sda_pin_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_cond) begin
        // repeated start behaves as a first start
        state <= FLMC_BYTE;
        bit_cnt <= 4'h0;
        byte_idx <= 2'd0;
        sda_pin_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= FLMC_IDLE;
        sda_pin_oe <= 1'b0;
      end else begin
        case (state)
          FLMC_IDLE: begin
            sda_pin_oe <= 1'b0;
          end
          FLMC_BYTE: begin
            if (scl_rise && bit_cnt != 4'd8) begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall && bit_cnt == 4'd8) begin
              // a read or a foreign address is left unanswered
              if (byte_ack) begin
                state <= FLMC_ACK;
                sda_pin_oe <= 1'b1;
              end else begin
                state <= FLMC_IDLE;
              end
              if (byte_idx == 2'd1) begin
                wr_addr <= shreg;
              end
              if (byte_idx == 2'd2) begin
                wr_data <= shreg;
                wr_stb <= 1'b1;
              end
            end
          end
          FLMC_ACK: begin
            if (scl_fall) begin
              sda_pin_oe <= 1'b0;
              state <= FLMC_BYTE;
              bit_cnt <= 4'h0;
              if (byte_idx != 2'd2) begin
                byte_idx <= byte_idx + 2'd1;
              end
            end
          end
          default: state <= FLMC_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/flmc_top.sv
// flash led mode control: registers, mode decode, flash timeout, thermal
`timescale 1ns/100ps
`default_nettype none
module flmc_top
  import flmc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // two-wire bus
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  // control pins
  input wire logic strobe_pin,
  input wire logic tx_pin,
  // thermal comparator indications
  input wire logic temp_trip,
  input wire logic temp_clear,
  // analog current sink and charge pump
  output logic sink_en,
  output logic sink_flash_range,
  output logic [3:0] sink_code,
  output logic pump_en,
  // status
  output logic timeout_state,
  output logic thermal_off
);
  logic [3:0] mode_select;
  logic [3:0] torch_level;
  logic [3:0] flash_level;
  logic [3:0] flash_time_limit;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [1:0] strobe_sync;
  logic [1:0] tx_sync;
  logic [1:0] trip_sync;
  logic [1:0] clear_sync;
  logic flash_req_prev;
  logic [31:0] tick_cnt;
  logic [MS_W-1:0] ms_cnt;

  // longest duration also serves the undefined codes above 7
  function automatic logic [MS_W-1:0] tmo_ms(input logic [3:0] code);
    logic [MS_W-1:0] ms;
    ms = TMO_MS_7;
    case (code)
      4'h0: ms = TMO_MS_0;
      4'h1: ms = TMO_MS_1;
      4'h2: ms = TMO_MS_2;
      4'h3: ms = TMO_MS_3;
      4'h4: ms = TMO_MS_4;
      4'h5: ms = TMO_MS_5;
      4'h6: ms = TMO_MS_6;
      default: ms = TMO_MS_7;
    endcase
    return ms;
  endfunction

  flmc_i2c_rx u_rx (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .scl_pin(scl_pin),
    .sda_pin_in(sda_pin_in),
    .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // register write decode
  wire wr_mode = wr_stb & (wr_addr == MODE_SELECT_ADDR);
  wire wr_torch = wr_stb & (wr_addr == TORCH_LEVEL_ADDR);
  wire wr_flash = wr_stb & (wr_addr == FLASH_LEVEL_ADDR);
  wire wr_tlim = wr_stb & (wr_addr == FLASH_TIME_LIMIT_ADDR);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_select <= MODE_SELECT_RST;
      torch_level <= TORCH_LEVEL_RST;
      flash_level <= FLASH_LEVEL_RST;
      flash_time_limit <= FLASH_TIME_LIMIT_RST;
    end else begin
      if (wr_mode) mode_select <= wr_data[3:0];
      if (wr_torch) torch_level <= wr_data[3:0];
      if (wr_flash) flash_level <= wr_data[3:0];
      if (wr_tlim) flash_time_limit <= wr_data[3:0];
    end
  end

  // pins are asynchronous to core_clk
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_sync <= 2'b00;
      tx_sync <= 2'b00;
      trip_sync <= 2'b00;
      clear_sync <= 2'b00;
    end else begin
      strobe_sync <= {strobe_sync[0], strobe_pin};
      tx_sync <= {tx_sync[0], tx_pin};
      trip_sync <= {trip_sync[0], temp_trip};
      clear_sync <= {clear_sync[0], temp_clear};
    end
  end

  // mode decode
  wire enabled = mode_select[MODE_EN_BIT];
  wire b1 = mode_select[MODE_B1_BIT];
  wire b2 = mode_select[MODE_B2_BIT];
  wire reg_flash = enabled & b1;
  wire reg_torch = enabled & ~b1 & ~b2;
  wire reg_ind = enabled & ~b1 & b2;
  wire strobe_act = strobe_sync[1] & ~mode_select[STROBE_INHIBIT_BIT];
  wire flash_req = enabled & (reg_flash | strobe_act);
  wire fresh_req = flash_req & ~flash_req_prev;
  wire burst = tx_sync[1];
  wire tick = (tick_cnt == 32'(TICK_CYC - 1));
  wire [MS_W-1:0] limit_ms = tmo_ms(flash_time_limit);
  wire expire = flash_req & ~fresh_req & (ms_cnt >= limit_ms);

  // millisecond time base and duration count, restarted per request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_req_prev <= 1'b0;
      tick_cnt <= 32'h0000_0000;
      ms_cnt <= '0;
    end else begin
      flash_req_prev <= flash_req;
      if (!flash_req || fresh_req) begin
        tick_cnt <= 32'h0000_0000;
        ms_cnt <= '0;
      end else if (tick) begin
        tick_cnt <= 32'h0000_0000;
        if (ms_cnt != limit_ms) ms_cnt <= ms_cnt + 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  // timeout holds until the enable bit drops; it can only set while enabled
  wire next_timeout = expire | (timeout_state & enabled);
  // hysteresis: trip wins over cool-down when both are seen
  wire next_thermal = trip_sync[1] | (thermal_off & ~clear_sync[1]);

  // sink selection, flash range only outside a radio burst
  wire use_flash = flash_req & ~burst;
  wire sink_on = enabled & ~next_thermal & ~next_timeout
               & (flash_req | reg_torch | reg_ind);
  wire [3:0] next_code = use_flash ? flash_level :
                         (reg_ind & ~flash_req) ? INDICATOR_CODE : torch_level;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_state <= 1'b0;
      thermal_off <= 1'b0;
      sink_en <= 1'b0;
      sink_flash_range <= 1'b0;
      sink_code <= 4'h0;
      pump_en <= 1'b0;
    end else begin
      timeout_state <= next_timeout;
      thermal_off <= next_thermal;
      sink_en <= sink_on;
      sink_flash_range <= use_flash;
      sink_code <= sink_on ? next_code : 4'h0;
      pump_en <= enabled & ~next_thermal;
    end
  end
endmodule
`default_nettype wire

//--- verif/flmc_host.sv
// two-wire bus master model that writes device registers
`timescale 1ns/100ps
`default_nettype none
module flmc_host
  import flmc_pkg::*;
(
  // clock
  input wire logic core_clk,
  // bus
  input wire logic sda_pin_oe,
  output logic scl_pin,
  output logic sda_pin_in
);
  logic sda_low;
  logic ack_ok;
  // open-drain wire with pull-up: low if either side pulls
  assign sda_pin_in = ~(sda_low | sda_pin_oe);
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
    ack_ok = 1'b1;
  end
  task automatic wc;
    repeat (8) @(negedge core_clk);
  endtask
  // eight bits msb first, then a released ack slot
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      sda_low = (i < 8) ? ~b[7-i] : 1'b0;
      wc;
      scl_pin = 1'b1;
      wc;
      if (i == 8) begin
        ack_ok &= ~sda_pin_in;
      end
      scl_pin = 1'b0;
    end
  endtask
  // chip address with write bit, register address, data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sda_low = 1'b1;
    wc;
    scl_pin = 1'b0;
    send({CHIP_ADDR, 1'b0});
    send(a);
    send(d);
    sda_low = 1'b1;
    wc;
    scl_pin = 1'b1;
    wc;
    sda_low = 1'b0;
    wc;
  endtask
endmodule
`default_nettype wire

//--- verif/flmc_top_monitor.sv
// assertion checker watching the flash led control outputs
`timescale 1ns/100ps
`default_nettype none
module flmc_top_monitor
#(
  parameter int TICK_CYC = 4
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pins
  input wire logic tx_pin,
  input wire logic temp_trip,
  input wire logic temp_clear,
  // outputs
  input wire logic sink_en,
  input wire logic sink_flash_range,
  input wire logic pump_en,
  input wire logic timeout_state,
  input wire logic thermal_off
);
  logic [31:0] fl_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_cool; (temp_clear && !temp_trip)[*5]; endsequence
  sequence s_hot; (temp_trip && temp_clear)[*5]; endsequence
  sequence s_burst; tx_pin[*4]; endsequence
  // slack covers sync delay and tick phase on top of the longest limit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fl_cnt <= '0;
    end else begin
      fl_cnt <= (sink_en && sink_flash_range) ? fl_cnt + 32'd1 : '0;
    end
  end
  a_trip_sets_off: assert property ($rose(temp_trip) |-> ##[1:4] thermal_off)
    else $error("thermal trip not taken");
  a_cool_resumes: assert property (s_cool |-> !thermal_off)
    else $error("thermal off after cooling");
  a_trip_wins: assert property (s_hot |-> thermal_off)
    else $error("trip lost to clear");
  a_heat_no_sink: assert property (thermal_off && $past(thermal_off) |-> !sink_en && !pump_en)
    else $error("sink or pump on while hot");
  a_tmo_no_sink: assert property (timeout_state && $past(timeout_state) |-> !sink_en)
    else $error("sink on in timeout");
  a_tmo_pump_on: assert property ($rose(timeout_state) && !thermal_off |-> pump_en)
    else $error("pump off at timeout");
  a_flash_bounded: assert property (fl_cnt <= 1100 * TICK_CYC + 16)
    else $error("flash longer than limit");
  a_burst_torch: assert property (s_burst ##0 sink_en |-> !sink_flash_range)
    else $error("flash level during burst");
endmodule
`default_nettype wire

//--- verif/flmc_top_test.sv
// self-checking testbench for the flash led control block
`timescale 1ns/100ps
`default_nettype none
module flmc_top_test;
  import flmc_pkg::*;
  localparam int TK = 4;
  logic core_clk, arst_n, strobe_pin, tx_pin, temp_trip, temp_clear;
  logic scl_pin, sda_pin_in, sda_pin_oe, sda_pin_out;
  logic sink_en, sink_flash_range, pump_en, timeout_state, thermal_off;
  logic [3:0] sink_code;
  logic [5:0] snk;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign snk = {sink_en, sink_flash_range, sink_code};
  flmc_top #(.TICK_CYC(TK)) dut (.core_clk(core_clk), .arst_n(arst_n),
    .scl_pin(scl_pin), .sda_pin_in(sda_pin_in), .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe),
    .strobe_pin(strobe_pin), .tx_pin(tx_pin), .temp_trip(temp_trip),
    .temp_clear(temp_clear), .sink_en(sink_en), .sink_flash_range(sink_flash_range),
    .sink_code(sink_code), .pump_en(pump_en), .timeout_state(timeout_state),
    .thermal_off(thermal_off));
  flmc_host host (.core_clk(core_clk), .sda_pin_oe(sda_pin_oe), .scl_pin(scl_pin),
    .sda_pin_in(sda_pin_in));
  task automatic chk(input string nm, input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pw;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_modes;
    host.wr(MODE_SELECT_ADDR, 8'h01);
    chk("torch", snk, 6'h27);
    host.wr(MODE_SELECT_ADDR, 8'h03);
    chk("flash", snk, 6'h3A);
    host.wr(MODE_SELECT_ADDR, 8'h05);
    chk("indicator", snk, 6'h20);
    host.wr(MODE_SELECT_ADDR, 8'h0F);
    chk("flash_b2", snk, 6'h3A);
    host.wr(MODE_SELECT_ADDR, 8'h0E);
    chk("shutdown", snk, 6'h00);
    $display("end modes");
  endtask
  task automatic t_levels;
    host.wr(TORCH_LEVEL_ADDR, 8'hF5);
    host.wr(FLASH_LEVEL_ADDR, 8'h0F);
    host.wr(8'h11, 8'h01);
    chk("unmapped", snk, 6'h00);
    host.wr(MODE_SELECT_ADDR, 8'h01);
    chk("torch_lvl", snk, 6'h25);
    host.wr(MODE_SELECT_ADDR, 8'h03);
    chk("flash_lvl", snk, 6'h3F);
    chk("acks", {4'h0, sda_pin_out, host.ack_ok}, 6'h01);
    $display("end levels");
  endtask
  task automatic t_pins;
    host.wr(MODE_SELECT_ADDR, 8'h01);
    strobe_pin = 1'b1;
    pw;
    chk("strobe", snk, 6'h3F);
    tx_pin = 1'b1;
    pw;
    chk("strobe_tx", snk, 6'h25);
    strobe_pin = 1'b0;
    host.wr(MODE_SELECT_ADDR, 8'h03);
    chk("reg_tx", snk, 6'h25);
    tx_pin = 1'b0;
    host.wr(MODE_SELECT_ADDR, 8'h09);
    strobe_pin = 1'b1;
    pw;
    chk("inhibit", snk, 6'h25);
    strobe_pin = 1'b0;
    $display("end pins");
  endtask
  task automatic t_heat;
    temp_trip = 1'b1;
    pw;
    chk("hot", {thermal_off, pump_en, sink_en, 3'h0}, 6'h20);
    temp_clear = 1'b1;
    pw;
    chk("both", {thermal_off, pump_en, sink_en, 3'h0}, 6'h20);
    temp_trip = 1'b0;
    pw;
    chk("cool", {thermal_off, pump_en, sink_en, 3'h0}, 6'h18);
    temp_clear = 1'b0;
    $display("end heat");
  endtask
  task automatic t_tmo;
    host.wr(FLASH_TIME_LIMIT_ADDR, 8'h00);
    host.wr(MODE_SELECT_ADDR, 8'h03);
    repeat (TK * 60 - 60) @(negedge core_clk);
    chk("before", snk, 6'h3F);
    repeat (40) @(negedge core_clk);
    chk("expired", {timeout_state, pump_en, sink_en, 3'h0}, 6'h30);
    host.wr(MODE_SELECT_ADDR, 8'h02);
    chk("cleared", {5'h00, timeout_state}, 6'h00);
    host.wr(MODE_SELECT_ADDR, 8'h03);
    chk("again", snk, 6'h3F);
    $display("end timeout");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // hang guard well above the expected run of about 8200 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      give_verdict;
    end
  end
  initial begin
    {strobe_pin, tx_pin, temp_trip, temp_clear} = 4'h0;
    arst_n = 1'b0;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    chk("reset", {snk[5:4], pump_en, timeout_state, thermal_off, sda_pin_oe}, 6'h00);
    repeat (4) @(negedge core_clk);
    t_modes;
    t_levels;
    t_pins;
    t_heat;
    t_tmo;
    give_verdict;
  end
endmodule
bind flmc_top flmc_top_monitor #(.TICK_CYC(TICK_CYC)) mon (.core_clk(core_clk),
  .arst_n(arst_n), .tx_pin(tx_pin), .temp_trip(temp_trip), .temp_clear(temp_clear),
  .sink_en(sink_en), .sink_flash_range(sink_flash_range), .pump_en(pump_en),
  .timeout_state(timeout_state), .thermal_off(thermal_off));
`default_nettype wire
